// ### src/cpsf_pkg.sv
// Package: status register layout, reset values and ALU op codes
`default_nettype none
package cpsf_pkg;
    localparam logic [7:0] CPSF_STATUS_ADDR  = 8'h03;
    localparam int         CPSF_BANK_BIT     = 5;
    localparam int         CPSF_EXPIRY_BIT   = 4;
    localparam int         CPSF_SLEEP_BIT    = 3;
    localparam int         CPSF_ZERO_BIT     = 2;
    localparam int         CPSF_NIBBLE_BIT   = 1;
    localparam int         CPSF_CARRY_BIT    = 0;
    localparam logic       CPSF_BANK_RST     = 1'h0;
    localparam logic       CPSF_EXPIRY_RST   = 1'h1;
    localparam logic       CPSF_SLEEP_RST    = 1'h1;
    localparam logic [2:0] CPSF_ALU_FLAG_RST = 3'h0;
    localparam logic [6:0] CPSF_DIRECT_MASK  = 7'h7F;

    typedef enum logic [3:0] {
        CPSF_OP_NONE,
        CPSF_OP_ADD,
        CPSF_OP_SUB,
        CPSF_OP_AND,
        CPSF_OP_IOR,
        CPSF_OP_XOR,
        CPSF_OP_PASS_A,
        CPSF_OP_PASS_B,
        CPSF_OP_COMPLEMENT,
        CPSF_OP_ROTATE_RIGHT,
        CPSF_OP_ROTATE_LEFT,
        CPSF_OP_NIBBLE_SWAP,
        CPSF_OP_CLEAR
    } cpsf_alu_op_t;

    typedef struct packed {
        logic zero;
        logic nibble;
        logic carry;
    } cpsf_alu_flags_t;

    typedef struct packed {
        logic         valid;
        cpsf_alu_op_t op;
        logic [7:0]   a;
        logic [7:0]   b;
        logic         carry_in;
        logic         sets_zero;
        logic         sets_arith;
        logic         sets_carry;
    } cpsf_alu_req_t;

    typedef struct packed {
        logic       write;
        logic [7:0] addr;
        logic [7:0] data;
    } cpsf_file_wr_t;
endpackage
`default_nettype wire

// ### src/cpsf_alu.sv
// ALU datapath that produces the result byte and the three result flags
`default_nettype none
module cpsf_alu
    import cpsf_pkg::*;
(
    input  wire cpsf_alu_req_t   req_in,
    output var  logic [7:0]      result_out,
    output var  cpsf_alu_flags_t flags_out
);
    logic [7:0] operand_b;
    logic       carry_seed;
    logic [4:0] low_sum;
    logic [8:0] full_sum;
    logic       is_arith;
    logic       is_sub;

    // subtract as add of two's complement
    assign is_sub     = (req_in.op == CPSF_OP_SUB);
    assign is_arith   = (req_in.op == CPSF_OP_ADD) || is_sub;
    assign operand_b  = is_sub ? ~req_in.b : req_in.b;
    assign carry_seed = is_sub;
    assign low_sum  = {1'b0, req_in.a[3:0]} + {1'b0, operand_b[3:0]} + {4'h0, carry_seed};
    assign full_sum = {1'b0, req_in.a} + {1'b0, operand_b} + {8'h00, carry_seed};

    always_comb begin
        result_out        = 8'h00;
        flags_out.carry   = req_in.carry_in;
        flags_out.nibble  = low_sum[4];
        case (req_in.op)
            CPSF_OP_ADD, CPSF_OP_SUB: begin
                result_out      = full_sum[7:0];
                flags_out.carry = full_sum[8];
            end
            CPSF_OP_AND:         result_out = req_in.a & req_in.b;
            CPSF_OP_IOR:         result_out = req_in.a | req_in.b;
            CPSF_OP_XOR:         result_out = req_in.a ^ req_in.b;
            CPSF_OP_PASS_A:      result_out = req_in.a;
            CPSF_OP_PASS_B:      result_out = req_in.b;
            CPSF_OP_COMPLEMENT:  result_out = ~req_in.a;
            // rotate loads carry from shifted-out bit
            CPSF_OP_ROTATE_RIGHT: begin
                result_out      = {req_in.carry_in, req_in.a[7:1]};
                flags_out.carry = req_in.a[0];
            end
            CPSF_OP_ROTATE_LEFT: begin
                result_out      = {req_in.a[6:0], req_in.carry_in};
                flags_out.carry = req_in.a[7];
            end
            CPSF_OP_NIBBLE_SWAP: result_out = {req_in.a[3:0], req_in.a[7:4]};
            CPSF_OP_CLEAR:       result_out = 8'h00;
            default:             result_out = 8'h00;
        endcase
        if (!is_arith) begin
            flags_out.nibble = 1'b0;
        end
        flags_out.zero = (result_out == 8'h00);
    end
endmodule
`default_nettype wire

// ### src/cpsf_bank_map.sv
// Direct address to bank-qualified data memory address, registered
`default_nettype none
module cpsf_bank_map
    import cpsf_pkg::*;
(
    input  wire  logic       core_clk_in,
    input  wire  logic       resetn_in,
    input  wire  logic       bank_in,
    input  wire  logic [6:0] direct_addr_in,
    output var   logic [7:0] mem_addr_out
);
    logic [7:0] mem_addr_d;

    // bank bit forms address bit 7
    assign mem_addr_d = {bank_in, direct_addr_in & CPSF_DIRECT_MASK};

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mem_addr_out <= 8'h00;
        end else begin
            mem_addr_out <= mem_addr_d;
        end
    end
endmodule
`default_nettype wire

// ### src/cpsf_status_reg.sv
// Processor status register: flags, reset-cause bits and bank select
`default_nettype none
module cpsf_status_reg
    import cpsf_pkg::*;
(
    input  wire  logic            core_clk_in,
    input  wire  logic            resetn_in,
    input  wire  cpsf_alu_req_t   alu_req_in,
    input  wire  cpsf_file_wr_t   file_wr_in,
    input  wire  logic            watchdog_clear_op_in,
    input  wire  logic            sleep_op_in,
    input  wire  logic            watchdog_timeout_in,
    input  wire  logic [6:0]      direct_addr_in,
    output var   logic [7:0]      status_out,
    output var   logic [7:0]      alu_result_out,
    output var   cpsf_alu_flags_t alu_flags_out,
    output var   logic [7:0]      mem_addr_out
);
    logic [1:0]      reserved_q;
    logic [1:0]      reserved_d;
    logic            bank_q;
    logic            bank_d;
    logic            expiry_q;
    logic            expiry_d;
    logic            sleep_q;
    logic            sleep_d;
    cpsf_alu_flags_t flags_q;
    cpsf_alu_flags_t flags_d;
    logic [7:0]      result;
    cpsf_alu_flags_t flags_new;
    cpsf_alu_req_t   alu_req;
    logic            hit;
    logic            alu_owns_flags;
    logic [7:0]      wdata;
    logic            timeout_meta_q;
    logic            timeout_sync_q;

    // Carry-in comes from the live carry flag
    always_comb begin
        alu_req          = alu_req_in;
        alu_req.carry_in = flags_q.carry;
    end

    cpsf_alu u_alu (
        .req_in     (alu_req),
        .result_out (result),
        .flags_out  (flags_new)
    );

    cpsf_bank_map u_bank_map (
        .core_clk_in    (core_clk_in),
        .resetn_in      (resetn_in),
        .bank_in        (bank_q),
        .direct_addr_in (direct_addr_in),
        .mem_addr_out   (mem_addr_out)
    );

    // status reachable as any file destination
    assign hit   = file_wr_in.write && (file_wr_in.addr[6:0] == CPSF_STATUS_ADDR[6:0]);
    assign wdata = file_wr_in.data;
    // any flag-affecting op blocks all three flag writes
    assign alu_owns_flags = alu_req_in.valid
                            && (alu_req_in.sets_zero || alu_req_in.sets_arith
                                || alu_req_in.sets_carry);

    // reserved bits are kept as software writes them
    assign reserved_d = hit ? wdata[7:6] : reserved_q;
    // zeroing op clears bank via written zero
    assign bank_d     = hit ? wdata[CPSF_BANK_BIT] : bank_q;

    // written data never reaches reset-cause flags
    // expiry flag, timeout clears with priority
    assign expiry_d = timeout_sync_q ? 1'b0 :
                      (watchdog_clear_op_in || sleep_op_in) ? 1'b1 : expiry_q;
    // sleep flag set by clear, cleared by sleep
    assign sleep_d  = sleep_op_in ? 1'b0 :
                      watchdog_clear_op_in ? 1'b1 : sleep_q;

    // flag updates from ALU override written data
    always_comb begin
        flags_d = flags_q;
        if (hit && !alu_owns_flags) begin
            flags_d.zero   = wdata[CPSF_ZERO_BIT];
            flags_d.nibble = wdata[CPSF_NIBBLE_BIT];
            flags_d.carry  = wdata[CPSF_CARRY_BIT];
        end
        if (alu_req_in.valid && alu_req_in.sets_zero) begin
            flags_d.zero = flags_new.zero;
        end
        if (alu_req_in.valid && alu_req_in.sets_arith) begin
            flags_d.nibble = flags_new.nibble;
        end
        if (alu_req_in.valid && alu_req_in.sets_carry) begin
            flags_d.carry = flags_new.carry;
        end
    end

    // Timeout comes from the watchdog oscillator domain
    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            timeout_meta_q <= 1'b0;
            timeout_sync_q <= 1'b0;
        end else begin
            timeout_meta_q <= watchdog_timeout_in;
            timeout_sync_q <= timeout_meta_q;
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            reserved_q <= 2'h0;
            bank_q     <= CPSF_BANK_RST;
            expiry_q   <= CPSF_EXPIRY_RST;
            sleep_q    <= CPSF_SLEEP_RST;
            flags_q    <= CPSF_ALU_FLAG_RST;
        end else begin
            reserved_q <= reserved_d;
            bank_q     <= bank_d;
            expiry_q   <= expiry_d;
            sleep_q    <= sleep_d;
            flags_q    <= flags_d;
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            status_out     <= 8'h18;
            alu_result_out <= 8'h00;
            alu_flags_out  <= CPSF_ALU_FLAG_RST;
        end else begin
            status_out     <= {reserved_d, bank_d, expiry_d, sleep_d,
                               flags_d.zero, flags_d.nibble, flags_d.carry};
            alu_result_out <= result;
            alu_flags_out  <= flags_new;
        end
    end
endmodule
`default_nettype wire

// ### tb/cpsf_status_reg_asserts.sv
// Checker: port timing relations of the status register
`default_nettype none
module cpsf_status_chk
    import cpsf_pkg::*;
(
    input wire logic            core_clk_in,
    input wire logic            resetn_in,
    input wire cpsf_alu_req_t   alu_req_in,
    input wire cpsf_file_wr_t   file_wr_in,
    input wire logic            watchdog_clear_op_in,
    input wire logic            sleep_op_in,
    input wire logic            watchdog_timeout_in,
    input wire logic [6:0]      direct_addr_in,
    input wire logic [7:0]      status_out,
    input wire logic [7:0]      alu_result_out,
    input wire cpsf_alu_flags_t alu_flags_out,
    input wire logic [7:0]      mem_addr_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);
    logic       w_hit;
    logic [7:0] wr_data;
    logic       req_all;
    assign w_hit   = file_wr_in.write && (file_wr_in.addr[6:0] == 7'h03);
    assign wr_data = file_wr_in.data;
    assign req_all = alu_req_in.valid && alu_req_in.sets_zero && alu_req_in.sets_arith
                     && alu_req_in.sets_carry;
    reset_value_a: assert property ($rose(resetn_in) |-> status_out == 8'h18)
        else $error("status not at reset value");
    sleep_clr_a: assert property (sleep_op_in |=> !status_out[3])
        else $error("sleep did not clear sleep flag");
    wdclr_set_a: assert property (watchdog_clear_op_in && !sleep_op_in |=> status_out[3])
        else $error("watchdog clear did not set sleep flag");
    timeout_clr_a: assert property (watchdog_timeout_in |-> ##[1:4] !status_out[4])
        else $error("timeout did not clear expiry flag");
    sleep_protect_a: assert property (
        w_hit && !sleep_op_in && !watchdog_clear_op_in |=> $stable(status_out[3]))
        else $error("software write changed sleep flag");
    alu_flags_a: assert property (req_all |=> status_out[2:0] == alu_flags_out)
        else $error("status flags differ from ALU flags");
    add_sum_a: assert property (alu_req_in.valid && alu_req_in.op == CPSF_OP_ADD |=>
        {alu_flags_out.carry, alu_result_out} == {1'b0, $past(alu_req_in.a)} + $past(alu_req_in.b))
        else $error("add result or carry wrong");
    neutral_write_a: assert property (w_hit && !alu_req_in.valid |=>
        {status_out[5], status_out[2:0]} == {$past(wr_data[5]), $past(wr_data[2:0])})
        else $error("flag-neutral write not stored");
    bank_addr_a: assert property ($past(resetn_in) |->
        mem_addr_out == {$past(status_out[5]), $past(direct_addr_in)})
        else $error("bank-qualified address wrong");
endmodule
`default_nettype wire

// ### tb/cpsf_core_model.sv
// Core-side model issuing ALU requests and file writes
`default_nettype none
module cpsf_core_model
    import cpsf_pkg::*;
(
    input  wire logic          core_clk_in,
    output var  cpsf_alu_req_t alu_req_out,
    output var  cpsf_file_wr_t file_wr_out
);
    initial begin
        alu_req_out = '0;
        file_wr_out = '0;
    end
    task automatic issue(input cpsf_alu_op_t op, input logic [7:0] a, b,
                         input logic [2:0] sets, input logic [7:0] addr, data);
        @(negedge core_clk_in);
        alu_req_out = '{op != CPSF_OP_NONE, op, a, b, 1'b0, sets[2], sets[1], sets[0]};
        file_wr_out = '{addr != 8'h00, addr, data & 8'h3F};
        @(negedge core_clk_in);
        alu_req_out = '{1'b0, op, ~a, ~b, 1'b1, 1'b0, 1'b0, 1'b0};
        file_wr_out = '{1'b0, ~addr, ~data};
    endtask
endmodule
`default_nettype wire

// ### tb/cpsf_status_reg_tb_top.sv
// Bench top for the processor status register
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module cpsf_status_reg_tb_top
    import cpsf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, wclr = 1'b0, slp = 1'b0, wto = 1'b0;
    logic rst_n;
    logic [6:0] daddr = 7'h00;
    logic [7:0] st, res, maddr;
    cpsf_alu_req_t areq;
    cpsf_file_wr_t fwr;
    cpsf_alu_flags_t fl;
    int n_mismatch = 0, total_checks = 0, seed = 39, est = 8'h18;
    cpsf_alu_op_t ops [5] = '{CPSF_OP_NONE, CPSF_OP_ADD, CPSF_OP_SUB,
                              CPSF_OP_ROTATE_RIGHT, CPSF_OP_ROTATE_LEFT};
    always #10 clk = ~clk;
    always @(negedge clk) daddr <= daddr + 7'h25;
    cpsf_core_model u_core (.core_clk_in(clk), .alu_req_out(areq), .file_wr_out(fwr));
    cpsf_status_reg u_dut (.core_clk_in(clk), .resetn_in(rst_n), .alu_req_in(areq),
        .file_wr_in(fwr), .watchdog_clear_op_in(wclr), .sleep_op_in(slp),
        .watchdog_timeout_in(wto), .direct_addr_in(daddr), .status_out(st),
        .alu_result_out(res), .alu_flags_out(fl), .mem_addr_out(maddr));
    function automatic int rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed & 32'h7FFF_FFFF;
    endfunction
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #500us;
        n_mismatch++;
        complete_run();
    end
    initial begin
        int k, a, b, c, r, dc, hit, d;
        logic [7:0] ad;
        // Real falling edge so the asynchronous reset fires
        rst_n = 1'b1;
        #5 rst_n = 1'b0;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        `CHK(st, 8'h18)
        for (int i = 0; i < 80; i++) begin
            k = rnd() % 5;
            a = rnd() & 8'hFF;
            b = rnd() & 8'hFF;
            d = rnd() & 8'h3F;
            hit = rnd() & 3;
            c = est & 1;
            ad = hit == 0 ? 8'h03 : hit == 1 ? 8'h83 : hit == 2 ? 8'h05 : 8'h00;
            case (k)
                1: r = a + b;
                2: r = a + (~b & 8'hFF) + 1;
                3: r = (c << 7) | (a >> 1) | ((a & 1) << 8);
                4: r = (a << 1) | c;
                default: r = 0;
            endcase
            dc = k == 1 ? ((a & 15) + (b & 15)) >> 4 : ((a & 15) + (~b & 15) + 1) >> 4;
            // Flag-affecting op blocks the written flags, bank still lands
            if (hit < 2) est = (est & (k == 0 ? 8'h18 : 8'h1F)) | (d & (k == 0 ? 8'h27 : 8'h20));
            if (k == 1 || k == 2) begin
                est[2] = r[7:0] == 0;
                est[1] = dc[0];
            end
            if (k != 0) est[0] = r[8];
            u_core.issue(ops[k], a[7:0], b[7:0], k == 0 ? 3'h0 : k < 3 ? 3'h7 : 3'h1, ad,
                         d[7:0]);
            `CHK(st, est[7:0])
            if (k != 0) `CHK(res, r[7:0])
        end
        u_core.issue(CPSF_OP_NONE, 8'h00, 8'h00, 3'h0, 8'h03, 8'h23);
        est = (est & 8'h18) | 8'h23;
        `CHK(st, est[7:0])
        u_core.issue(CPSF_OP_CLEAR, 8'h00, 8'h00, 3'h4, 8'h83, 8'h00);
        est = (est & 8'h1B) | 8'h04;
        `CHK(st, est[7:0])
        @(negedge clk) slp = 1'b1;
        @(negedge clk) slp = 1'b0;
        est = (est & 8'hE7) | 8'h10;
        `CHK(st, est[7:0])
        @(negedge clk) wclr = 1'b1;
        @(negedge clk) wclr = 1'b0;
        est = est | 8'h18;
        `CHK(st, est[7:0])
        @(negedge clk) wto = 1'b1;
        @(negedge clk) wto = 1'b0;
        for (int w = 0; w < 8 && st[4] !== 1'b0; w++) @(negedge clk);
        `CHK(st, est[7:0] & 8'hEF)
        complete_run();
    end
endmodule
bind cpsf_status_reg cpsf_status_chk u_chk (.core_clk_in(core_clk_in),
    .resetn_in(resetn_in), .alu_req_in(alu_req_in), .file_wr_in(file_wr_in),
    .watchdog_clear_op_in(watchdog_clear_op_in), .sleep_op_in(sleep_op_in),
    .watchdog_timeout_in(watchdog_timeout_in), .direct_addr_in(direct_addr_in),
    .status_out(status_out), .alu_result_out(alu_result_out),
    .alu_flags_out(alu_flags_out), .mem_addr_out(mem_addr_out));
`default_nettype wire
